// ---- rtl/dtds_core.sv ----
// dtds_core: disk transfer datapath, counters, error status and register slave
// assumes drive pins asynchronous, memory channel and Avalon-MM on the core clock
//
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
module dtds_core
   import dtds_pkg::*;
(
   input  wire logic              i_core_clk,
   input  wire logic              i_arst_n,
   input  wire logic              i_ce,
   input  wire logic [5:0]        i_avs_address,
   input  wire logic              i_avs_read,
   input  wire logic              i_avs_write,
   input  wire logic [31:0]       i_avs_writedata,
   output logic [31:0]            o_avs_readdata,
   output logic                   o_avs_waitrequest,
   input  wire logic              i_disk_bit_stb,
   input  wire logic              i_disk_rd_bit,
   input  wire logic              i_sector_mark,
   input  wire logic              i_index,
   input  wire logic              i_end_of_pack,
   input  wire logic              i_read_only,
   output logic                   o_disk_wr_bit,
   output logic                   o_disk_write_gate,
   output logic                   o_mem_req,
   output logic                   o_mem_we,
   output logic [CNT_W-1:0]       o_mem_addr,
   output logic [WORD_W-1:0]      o_mem_wdata,
   input  wire logic              i_mem_ack,
   input  wire logic [WORD_W-1:0] i_mem_rdata,
   output logic                   o_busy,
   output logic                   o_bad_cylinder_address,
   output logic                   o_bad_head_address,
   output logic                   o_bad_sector_address
);

   logic [NPIN-1:0]   s1_q, s2_q, s3_q, lvl_q, lvl_d1_q, rise;
   logic              ack_q, wr_go, cmd_start, cmd_clr, go, pe_now, wp_now, rd_mode;
   logic [31:0]       rdata_q;
   dtds_state_e       st_q;
   dtds_mode_s        mode_q;
   dtds_daddr_s       daddr_q;
   dtds_err_s         err_q, err_set;
   logic [CNT_W-1:0]  wc_q, ca_q;
   logic [WORD_W-1:0] buf_q, lpr_q, sd_word, load_word;
   logic              buf_full_q, tx_q, hdr_exp_q, idx_seen_q, lock_en_q;
   logic [7:0]        lock_lim_q;
   logic [SWC_W-1:0]  swc_q;
   logic              sd_need, sd_done, sd_par_ok, data_evt, end_now, wc_zero;

   // three-stage pin sync; a change counts once stages two and three agree
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s1_q     <= '0;
         s2_q     <= '0;
         s3_q     <= '0;
         lvl_q    <= '0;
         lvl_d1_q <= '0;
      end else if (i_ce) begin
         s1_q     <= {i_read_only, i_end_of_pack, i_index, i_sector_mark, i_disk_rd_bit, i_disk_bit_stb};
         s2_q     <= s1_q;
         s3_q     <= s2_q;
         lvl_q    <= (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));
         lvl_d1_q <= lvl_q;
      end
   end
   assign rise = lvl_q & ~lvl_d1_q;

   // one wait state: request at edge 0, answer stands at edge 1
   assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
   assign wr_go     = i_avs_write & ack_q;
   assign cmd_start = wr_go & (i_avs_address == OFS_CTRL) & i_avs_writedata[CTL_START];
   assign cmd_clr   = wr_go & (i_avs_address == OFS_CTRL) & i_avs_writedata[CTL_CLR];

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ack_q <= 1'b0;
      end else if (i_ce) begin
         ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
      end
   end

   // address legality is live, not latched
   assign o_bad_cylinder_address = daddr_q.cyl >= CYL_LIMIT;
   assign o_bad_head_address     = daddr_q.head >= HEAD_LIMIT;
   assign o_bad_sector_address   = daddr_q.sec >= SEC_LIMIT;

   assign pe_now = cmd_start & (o_busy | (i_avs_writedata[CTL_WRITE] & i_avs_writedata[CTL_WCHK])
                   | o_bad_cylinder_address | o_bad_head_address | o_bad_sector_address);
   assign wp_now = cmd_start & ~pe_now & i_avs_writedata[CTL_WRITE]
                   & (lvl_q[PIN_RO] | (lock_en_q & (daddr_q.cyl <= lock_lim_q)));
   assign go      = cmd_start & ~pe_now & ~wp_now;
   assign o_busy  = st_q != ST_IDLE;
   assign rd_mode = ~mode_q.wr & ~mode_q.wchk;
   assign wc_zero = wc_q == CNT_ZERO;

   // a protected or illegal start never leaves idle
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rdata_q <= '0;
      end else if (i_ce && i_avs_read && !ack_q) begin
         unique case (i_avs_address)
            OFS_CTRL:   rdata_q <= 32'({err_q.sector_words_done, mode_q.wchk, mode_q.wr, o_busy});
            OFS_WC:     rdata_q <= 32'(wc_q);
            OFS_CA:     rdata_q <= 32'(ca_q);
            OFS_DADDR:  rdata_q <= 32'(daddr_q);
            OFS_ERR:    rdata_q <= 32'({o_bad_sector_address, o_bad_head_address, o_bad_cylinder_address, err_q});
            OFS_LOCK:   rdata_q <= 32'({lock_en_q, lock_lim_q});
            OFS_SWC:    rdata_q <= 32'(swc_q);
            OFS_BUF_LO: rdata_q <= 32'(buf_q[HALF_W-1:0]);
            OFS_BUF_HI: rdata_q <= 32'(buf_q[WORD_W-1:HALF_W]);
            OFS_LPR_LO: rdata_q <= 32'(lpr_q[HALF_W-1:0]);
            OFS_LPR_HI: rdata_q <= 32'(lpr_q[WORD_W-1:HALF_W]);
            default:    rdata_q <= '0;
         endcase
      end
   end
   assign o_avs_readdata = rdata_q;

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         lock_lim_q <= '0;
         lock_en_q  <= 1'b0;
      end else if (i_ce && wr_go && i_avs_address == OFS_LOCK) begin
         lock_lim_q <= i_avs_writedata[7:0];
         lock_en_q  <= i_avs_writedata[LOCK_EN];
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         mode_q <= '0;
      end else if (i_ce && go) begin
         mode_q <= '{wr: i_avs_writedata[CTL_WRITE], wchk: i_avs_writedata[CTL_WCHK]};
      end
   end

   dtds_serdes u_serdes (
      .i_core_clk  (i_core_clk),
      .i_arst_n    (i_arst_n),
      .i_ce        (i_ce),
      .i_restart   (rise[PIN_SMK] & ~tx_q),
      .i_bit_stb   (rise[PIN_STB]),
      .i_bit       (lvl_q[PIN_DAT]),
      .i_tx        (tx_q),
      .i_load_word (load_word),
      .o_need      (sd_need),
      .o_word_done (sd_done),
      .o_par_ok    (sd_par_ok),
      .o_tx_bit    (o_disk_wr_bit),
      .o_word      (sd_word)
   );

   assign load_word = (st_q == ST_CHECK) ? ~lpr_q : buf_q;
   assign data_evt  = (st_q == ST_DATA) & (sd_done | sd_need);
   // writes stop only on a word boundary so the last word goes out whole
   assign end_now   = wc_zero & ~buf_full_q & (tx_q ? sd_need : 1'b1);
   assign o_disk_write_gate = tx_q;

   // sequencer: header search, sector data, sector check word
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_q       <= ST_IDLE;
         tx_q       <= 1'b0;
         hdr_exp_q  <= 1'b0;
         idx_seen_q <= 1'b0;
         swc_q      <= '0;
         lpr_q      <= '0;
      end else if (i_ce) begin
         unique case (st_q)
            ST_IDLE: begin
               tx_q <= 1'b0;
               if (go) begin
                  st_q       <= ST_SEARCH;
                  idx_seen_q <= 1'b0;
                  hdr_exp_q  <= 1'b0;
               end
            end
            ST_SEARCH: begin
               if (sd_need) begin
                  tx_q <= 1'b0;
               end
               if (rise[PIN_SMK]) begin
                  hdr_exp_q <= 1'b1;
               end
               if (rise[PIN_EOP] && !wc_zero) begin
                  st_q <= ST_IDLE;
               end else if (rise[PIN_IDX] && idx_seen_q) begin
                  st_q <= ST_IDLE;
               end else if (sd_done && hdr_exp_q) begin
                  hdr_exp_q <= 1'b0;
                  if (sd_par_ok && sd_word[DADDR_W-1:0] == daddr_q) begin
                     st_q  <= ST_DATA;
                     tx_q  <= mode_q.wr;
                     swc_q <= '0;
                     lpr_q <= '0;
                  end
               end
               if (rise[PIN_IDX]) begin
                  idx_seen_q <= 1'b1;
               end
            end
            ST_DATA: begin
               if (rise[PIN_EOP] && !wc_zero) begin
                  st_q <= ST_IDLE;
               end else if (end_now) begin
                  st_q <= ST_IDLE;
               end else if (data_evt) begin
                  swc_q <= swc_q + 1'b1;
                  lpr_q <= lpr_q ^ (tx_q ? buf_q : sd_word);
                  if (swc_q + 1'b1 == SEC_WORDS) begin
                     st_q <= ST_CHECK;
                  end
               end
            end
            ST_CHECK: begin
               if (sd_done || sd_need) begin
                  st_q       <= wc_zero ? ST_IDLE : ST_SEARCH;
                  idx_seen_q <= 1'b0;
                  hdr_exp_q  <= 1'b0;
               end
            end
         endcase
      end
   end

   // the sector address steps on to the next sector after each check word unless the word count has reached zero
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         daddr_q <= '0;
      end else if (i_ce) begin
         if (st_q == ST_CHECK && (sd_done || sd_need) && !wc_zero) begin
            daddr_q.sec <= daddr_q.sec + 1'b1;
         end else if (wr_go && i_avs_address == OFS_DADDR) begin
            daddr_q <= i_avs_writedata[DADDR_W-1:0];
         end
      end
   end

   // buffer: read words wait here for memory; write and check words are prefetched
   assign o_mem_req   = o_busy & (rd_mode ? buf_full_q : (~buf_full_q & ~wc_zero));
   assign o_mem_we    = rd_mode;
   assign o_mem_addr  = ca_q;
   assign o_mem_wdata = buf_q;

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         buf_q      <= '0;
         buf_full_q <= 1'b0;
      end else if (i_ce) begin
         if (go) begin
            buf_full_q <= 1'b0;
         end else if (o_mem_req && i_mem_ack) begin
            buf_full_q <= ~rd_mode;
            if (!rd_mode) begin
               buf_q <= i_mem_rdata;
            end
         end else if (st_q == ST_DATA && sd_done && rd_mode && !buf_full_q) begin
            buf_q      <= sd_word;
            buf_full_q <= 1'b1;
         end else if (data_evt && !rd_mode && buf_full_q) begin
            buf_full_q <= 1'b0;
         end
      end
   end

   // a transfer step outranks a host load that lands in the same cycle
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wc_q <= '0;
         ca_q <= '0;
      end else if (i_ce) begin
         if (o_mem_req && i_mem_ack) begin
            wc_q <= wc_q + CNT_ONE;
            ca_q <= ca_q + CNT_ONE;
         end else if (wr_go && i_avs_address == OFS_WC) begin
            wc_q <= i_avs_writedata[CNT_W-1:0];
         end else if (wr_go && i_avs_address == OFS_CA) begin
            ca_q <= i_avs_writedata[CNT_W-1:0];
         end
      end
   end

   always_comb begin
      err_set                           = '0;
      err_set.header_parity_error       = (st_q == ST_SEARCH) & sd_done & hdr_exp_q & ~sd_par_ok;
      err_set.word_parity_error         = (st_q != ST_SEARCH) & sd_done & ~sd_par_ok;
      err_set.longitudinal_parity_error = (st_q == ST_CHECK) & sd_done & ~(&(lpr_q ^ sd_word));
      err_set.write_check_mismatch      = (st_q == ST_DATA) & sd_done & mode_q.wchk & buf_full_q
                                          & (buf_q != sd_word);
      err_set.missed_transfer           = data_evt & ~end_now & (rd_mode == buf_full_q);
      err_set.illegal_command_sequence  = pe_now;
      err_set.sector_header_missing     = (st_q == ST_SEARCH) & rise[PIN_IDX] & idx_seen_q
                                          & ~(rise[PIN_EOP] & ~wc_zero);
      err_set.write_protect_violation   = wp_now;
      err_set.end_of_pack               = o_busy & rise[PIN_EOP] & ~wc_zero;
      err_set.sector_words_done         = data_evt & ~end_now & (swc_q + 1'b1 == SEC_WORDS) & ~err_set.end_of_pack;
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         err_q <= '0;
      end else if (i_ce) begin
         err_q <= (cmd_clr ? '0 : err_q) | err_set;
      end
   end

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_arst_n || !i_ce);

   sequence s_ack;
      o_mem_req && i_mem_ack;
   endsequence

   property p_wc_inc;
      s_ack |=> wc_q == $past(wc_q) + CNT_ONE;
   endproperty
   a_wc_inc: assert property (p_wc_inc) else $error("word count did not step");

   property p_ca_inc;
      s_ack |=> ca_q == $past(ca_q) + CNT_ONE;
   endproperty
   a_ca_inc: assert property (p_ca_inc) else $error("address did not step");

   property p_sticky;
      !cmd_clr |=> (err_q | $past(err_q)) == err_q;
   endproperty
   a_sticky: assert property (p_sticky) else $error("error bit dropped without clear");

   property p_pe;
      cmd_start && o_busy |=> err_q.illegal_command_sequence && o_busy;
   endproperty
   a_pe: assert property (p_pe) else $error("start while busy not flagged");

   property p_wp;
      cmd_start && !pe_now && i_avs_writedata[CTL_WRITE] && lvl_q[PIN_RO]
         |=> err_q.write_protect_violation && !o_busy;
   endproperty
   a_wp: assert property (p_wp) else $error("protected write started");

   sequence s_lost_rev;
      st_q == ST_SEARCH && rise[PIN_IDX] && idx_seen_q && !rise[PIN_EOP];
   endsequence

   property p_hnf;
      s_lost_rev |=> st_q == ST_IDLE ##0 err_q.sector_header_missing;
   endproperty
   a_hnf: assert property (p_hnf) else $error("header search not ended after revolution");

   property p_swc;
      data_evt && !end_now && !err_set.end_of_pack && swc_q == SEC_WORDS - 1'b1
         |=> st_q == ST_CHECK && err_q.sector_words_done && swc_q == SEC_WORDS;
   endproperty
   a_swc: assert property (p_swc) else $error("sector end not reached");

   property p_stop;
      st_q == ST_DATA && end_now && !rise[PIN_EOP] |=> st_q == ST_IDLE ##1 !o_mem_req;
   endproperty
   a_stop: assert property (p_stop) else $error("transfer ran past zero count");

   property p_bad_cyl;
      wr_go && i_avs_address == OFS_DADDR && i_avs_writedata[DADDR_W-1:DADDR_W-8] >= CYL_LIMIT
         && !(st_q == ST_CHECK && (sd_done || sd_need) && !wc_zero) |=> o_bad_cylinder_address;
   endproperty
   a_bad_cyl: assert property (p_bad_cyl) else $error("bad cylinder not shown");

   property p_wait;
      (i_avs_read || i_avs_write) && !ack_q |=> !o_avs_waitrequest;
   endproperty
   a_wait: assert property (p_wait) else $error("bus answer late");

endmodule : dtds_core

// ---- rtl/dtds_pkg.sv ----
// dtds_pkg: constants, field layouts and carriers of the disk transfer datapath
// assumes a single core clock; every design file imports the whole package
// What this block does
// - a 36-bit buffer register is the data exchange point with the host
// - a 36-bit shift register assembles read bits and serializes write words
// - a 36-bit register accumulates odd parity per bit position over a sector
// - host loads word count as two's complement; each word moved increments it
// - host loads start address; each word moved advances it by one
// - a 7-bit counter counts the words moved within the current sector
// - a done flag sets once the sector's full word count has been moved
// - a header word read with bad parity sets the header parity error
// - a data word read with bad parity sets the word parity error
// - a failing per-position sector parity sets the longitudinal error
// - write-check compares memory and disk words; any difference sets mismatch
// - a word that misses its memory transfer sets the timing error
// - an illegal command sequence from the host sets the programming error
// - a full revolution without the wanted header sets header missing
// - a write violating either write protection sets the protect error
// - bad cylinder, head and sector flags follow the address register live
// - reaching the end of pack before the count completes sets end of pack
package dtds_pkg;

   localparam int unsigned WORD_W  = 36;
   localparam int unsigned CNT_W   = 18;
   localparam int unsigned SWC_W   = 7;
   localparam int unsigned BCNT_W  = 6;
   localparam int unsigned NPIN    = 6;
   localparam int unsigned ERR_W   = 10;
   localparam int unsigned DADDR_W = 17;
   localparam int unsigned HALF_W  = 18;

   // serial word: 36 data bits then one odd parity bit
   localparam logic [BCNT_W-1:0] BIT_PAR    = 6'h24;
   localparam logic [SWC_W-1:0]  SEC_WORDS  = 7'h40;
   localparam logic [7:0]        CYL_LIMIT  = 8'hC8;
   localparam logic [4:0]        HEAD_LIMIT = 5'h14;
   localparam logic [3:0]        SEC_LIMIT  = 4'hA;

   // pin vector positions
   localparam int unsigned PIN_STB = 0;
   localparam int unsigned PIN_DAT = 1;
   localparam int unsigned PIN_SMK = 2;
   localparam int unsigned PIN_IDX = 3;
   localparam int unsigned PIN_EOP = 4;
   localparam int unsigned PIN_RO  = 5;

   // register byte offsets
   localparam logic [5:0] OFS_CTRL   = 6'h00;
   localparam logic [5:0] OFS_WC     = 6'h04;
   localparam logic [5:0] OFS_CA     = 6'h08;
   localparam logic [5:0] OFS_DADDR  = 6'h0C;
   localparam logic [5:0] OFS_ERR    = 6'h10;
   localparam logic [5:0] OFS_LOCK   = 6'h14;
   localparam logic [5:0] OFS_SWC    = 6'h18;
   localparam logic [5:0] OFS_BUF_LO = 6'h1C;
   localparam logic [5:0] OFS_BUF_HI = 6'h20;
   localparam logic [5:0] OFS_LPR_LO = 6'h24;
   localparam logic [5:0] OFS_LPR_HI = 6'h28;

   // control and lock field positions
   localparam int unsigned CTL_START = 0;
   localparam int unsigned CTL_WRITE = 1;
   localparam int unsigned CTL_WCHK  = 2;
   localparam int unsigned CTL_CLR   = 3;
   localparam int unsigned LOCK_EN   = 8;

   localparam logic [CNT_W-1:0] CNT_ZERO = 18'h00000;
   localparam logic [CNT_W-1:0] CNT_ONE  = 18'h00001;

   typedef struct packed {
      logic [7:0] cyl;
      logic [4:0] head;
      logic [3:0] sec;
   } dtds_daddr_s;

   typedef struct packed {
      logic end_of_pack;
      logic write_protect_violation;
      logic sector_header_missing;
      logic illegal_command_sequence;
      logic missed_transfer;
      logic write_check_mismatch;
      logic longitudinal_parity_error;
      logic word_parity_error;
      logic header_parity_error;
      logic sector_words_done;
   } dtds_err_s;

   typedef struct packed {
      logic wr;
      logic wchk;
   } dtds_mode_s;

   typedef enum logic [1:0] {ST_IDLE, ST_SEARCH, ST_DATA, ST_CHECK} dtds_state_e;

endpackage : dtds_pkg

// ---- rtl/dtds_serdes.sv ----
// dtds_serdes: 36-bit serial shifter with odd word parity, both directions
// assumes bit strobes and data already synchronised to the core clock
module dtds_serdes
   import dtds_pkg::*;
(
   input  wire logic              i_core_clk,
   input  wire logic              i_arst_n,
   input  wire logic              i_ce,
   input  wire logic              i_restart,
   input  wire logic              i_bit_stb,
   input  wire logic              i_bit,
   input  wire logic              i_tx,
   input  wire logic [WORD_W-1:0] i_load_word,
   output logic                   o_need,
   output logic                   o_word_done,
   output logic                   o_par_ok,
   output logic                   o_tx_bit,
   output logic [WORD_W-1:0]      o_word
);

   logic [WORD_W-1:0] sh_q;
   logic [BCNT_W-1:0] cnt_q;
   logic              par_q;

   // word taken at the first bit slot of each serial word
   assign o_need = i_tx & i_bit_stb & (cnt_q == '0);

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_q <= '0;
      end else if (i_ce) begin
         if (i_restart) begin
            cnt_q <= '0;
         end else if (i_bit_stb) begin
            cnt_q <= (cnt_q == BIT_PAR) ? '0 : cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sh_q        <= '0;
         par_q       <= 1'b0;
         o_tx_bit    <= 1'b0;
         o_word      <= '0;
         o_word_done <= 1'b0;
         o_par_ok    <= 1'b0;
      end else if (i_ce) begin
         o_word_done <= 1'b0;
         if (i_bit_stb && !i_restart) begin
            if (i_tx) begin
               if (cnt_q == '0) begin
                  o_tx_bit <= i_load_word[WORD_W-1];
                  sh_q     <= {i_load_word[WORD_W-2:0], 1'b0};
                  par_q    <= ~(^i_load_word);
               end else if (cnt_q == BIT_PAR) begin
                  o_tx_bit <= par_q;
               end else begin
                  o_tx_bit <= sh_q[WORD_W-1];
                  sh_q     <= {sh_q[WORD_W-2:0], 1'b0};
               end
            end else if (cnt_q == BIT_PAR) begin
               o_word      <= sh_q;
               o_par_ok    <= ^{sh_q, i_bit};
               o_word_done <= 1'b1;
            end else begin
               sh_q <= {sh_q[WORD_W-2:0], i_bit};
            end
         end
      end
   end

endmodule : dtds_serdes

// ---- bench/dtds_drive_model.sv ----
// dtds_drive_model: far side, drive index and protect pins plus memory channel
// assumes the core clock; memory answers only on odd counts, so it stalls
module dtds_drive_model
   import dtds_pkg::*;
(
   input  wire logic         i_core_clk,
   input  wire logic         i_arst_n,
   input  wire logic         i_ro,
   input  wire logic         i_mem_req,
   output logic              o_index,
   output logic              o_read_only,
   output logic              o_mem_ack,
   output logic [WORD_W-1:0] o_mem_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   // fixed word on ack, its inverse otherwise, so a stale or missed load shows
   localparam logic [WORD_W-1:0] MEM_WORD = 36'h123456789;
   logic [7:0] cnt_q;
   assign o_read_only = i_ro;
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_q       <= 8'h00;
         o_index     <= 1'b0;
         o_mem_ack   <= 1'b0;
         o_mem_rdata <= 36'h000000000;
      end else begin
         cnt_q       <= cnt_q + 8'h01;
         o_index     <= (cnt_q < 8'h08);
         o_mem_ack   <= i_mem_req & ~o_mem_ack & cnt_q[0];
         o_mem_rdata <= (i_mem_req & ~o_mem_ack & cnt_q[0]) ? MEM_WORD : ~MEM_WORD;
      end
   end
endmodule : dtds_drive_model

// ---- bench/dtds_core_tb.sv ----
// dtds_core_tb: register-level scenarios on status, counters and refusals
// assumes one wait state on the bus; drive serial pins held idle
module dtds_core_tb;
   import dtds_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic              clk, arst_n, wr_s, rd_s, ro, wait_s, idx, rop, mreq, mack, busy, bc, bh, bs, mwe;
   logic [5:0]        adr;
   logic [31:0]       wd, rdd, d;
   logic [WORD_W-1:0] mrd;
   int                fail_count = 0;
   int                n_tests = 0;
   dtds_core i_dtds_core (.i_core_clk(clk), .i_arst_n(arst_n), .i_ce(1'b1), .i_avs_address(adr),
      .i_avs_read(rd_s), .i_avs_write(wr_s), .i_avs_writedata(wd), .o_avs_readdata(rdd),
      .o_avs_waitrequest(wait_s), .i_disk_bit_stb(1'b0), .i_disk_rd_bit(1'b0), .i_sector_mark(1'b0),
      .i_index(idx), .i_end_of_pack(1'b0), .i_read_only(rop), .o_disk_wr_bit(), .o_disk_write_gate(),
      .o_mem_req(mreq), .o_mem_we(mwe), .o_mem_addr(), .o_mem_wdata(), .i_mem_ack(mack), .i_mem_rdata(mrd),
      .o_busy(busy), .o_bad_cylinder_address(bc), .o_bad_head_address(bh), .o_bad_sector_address(bs));
   dtds_drive_model i_dtds_drive_model (.i_core_clk(clk), .i_arst_n(arst_n), .i_ro(ro), .i_mem_req(mreq),
      .o_index(idx), .o_read_only(rop), .o_mem_ack(mack), .o_mem_rdata(mrd));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] v);
      @(posedge clk);
      adr  <= a;
      wd   <= v;
      wr_s <= w;
      rd_s <= ~w;
      @(posedge clk);
      while (wait_s !== 1'b0) @(posedge clk);
      d = rdd;
      wr_s <= 1'b0;
      rd_s <= 1'b0;
   endtask : bus
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s exp %h got %h", s, e, g);
      end
   endtask : chk
   task automatic rchk(input string s, input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(s, e, d);
   endtask : rchk
   task automatic t_counts;
      rchk("err after reset", OFS_ERR, 32'h0);
      bus(1'b1, OFS_WC, 32'h0003FFFF);
      rchk("word count", OFS_WC, 32'h0003FFFF);
      bus(1'b1, OFS_CA, 32'h00012345);
      rchk("address", OFS_CA, 32'h00012345);
   endtask : t_counts
   task automatic t_bad_addr;
      logic [31:0] tbl [3];
      tbl = '{32'h00019000, 32'h00000140, 32'h0000000A};
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, OFS_DADDR, tbl[i]);
         @(posedge clk);
         chk("bad flags", 32'h1 << i, {29'h0, bs, bh, bc});
         bus(1'b1, OFS_CTRL, 32'h1);
         rchk("refused start", OFS_ERR, (32'h400 << i) | 32'h40);
         bus(1'b1, OFS_DADDR, 32'h0);
         bus(1'b1, OFS_CTRL, 32'h8);
         rchk("cleared", OFS_ERR, 32'h0);
      end
   endtask : t_bad_addr
   task automatic t_protect;
      ro <= 1'b1;
      bus(1'b1, OFS_WC, 32'h0003FFFF);
      bus(1'b1, OFS_CTRL, 32'h3);
      rchk("protect pin", OFS_ERR, 32'h100);
      ro <= 1'b0;
      bus(1'b1, OFS_CTRL, 32'h8);
      bus(1'b1, OFS_LOCK, 32'h105);
      bus(1'b1, OFS_DADDR, 32'h00000A00);
      bus(1'b1, OFS_CTRL, 32'h3);
      rchk("protect lock", OFS_ERR, 32'h100);
      bus(1'b1, OFS_LOCK, 32'h0);
      bus(1'b1, OFS_DADDR, 32'h0);
      bus(1'b1, OFS_CTRL, 32'h8);
   endtask : t_protect
   task automatic t_search;
      bus(1'b1, OFS_CTRL, 32'h1);
      @(posedge clk);
      chk("busy", 32'h1, {31'h0, busy});
      // two index marks come within about 520 cycles
      repeat (600) @(posedge clk);
      rchk("header missing", OFS_ERR, 32'h80);
      rchk("no words moved", OFS_WC, 32'h0003FFFF);
   endtask : t_search
   // one-word write fetch; a second start while busy must be refused
   task automatic t_fetch;
      bus(1'b1, OFS_CTRL, 32'h8);
      bus(1'b1, OFS_WC, 32'h0003FFFF);
      bus(1'b1, OFS_CA, 32'h00000100);
      bus(1'b1, OFS_CTRL, 32'h3);
      bus(1'b1, OFS_CTRL, 32'h1);
      rchk("refused busy start", OFS_ERR, 32'h40);
      rchk("mode", OFS_CTRL, 32'h3);
      chk("mem dir", 32'h0, {31'h0, mwe});
      repeat (8) @(posedge clk);
      rchk("count done", OFS_WC, 32'h0);
      rchk("address step", OFS_CA, 32'h101);
      // halves of the memory word that the partner returns
      rchk("buffer lo", OFS_BUF_LO, 32'h16789);
      rchk("buffer hi", OFS_BUF_HI, 32'h48D1);
   endtask : t_fetch
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      end_of_test();
   end
   initial begin
      arst_n = 1'b0; wr_s = 1'b0; rd_s = 1'b0; adr = 6'h00; wd = 32'h0; ro = 1'b0;
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      t_counts();
      t_bad_addr();
      t_protect();
      t_search();
      t_fetch();
      end_of_test();
   end
endmodule : dtds_core_tb
